//--- tstx_sched.sv
// Tyre sensor transmit scheduler: mode control, burst timing, Manchester encoder
//
// Functional notes
// R01: Every sent bit is Manchester coded
// R02: Bit rate never above 4.096 kbit/s
// R03: Parked mode sends no words except the identity word
// R04: Motion closed: moving mode, eight words per minute
// R05: Motion opens: keep bursting through hold interval
// R06: Hold expired and open: back to parked
// R07: Wake-up field sends the identity code
// R08: One is high-low, zero is low-high
`timescale 1ns/1ns
module tstx_sched
	import tstx_pkg::*;
#(
	parameter int unsigned WORD_W       = DEF_WORD_W,   // Bits per word
	parameter int unsigned HALF_CYC     = HALF_BIT_CYC, // Clocks per half bit
	parameter int unsigned PERIOD_TICKS_P = PERIOD_TICKS, // Half bits per burst period
	parameter int unsigned HOLD_PERIODS = DEF_HOLD_MIN  // Hold interval in periods
) (
	input  wire logic              core_clk,     // Core clock, 125 MHz
	input  wire logic              rst_b,        // Asynchronous reset, active low
	input  wire logic              motion_closed, // Motion switch closed
	input  wire logic              lf_field,     // Wake-up field detected
	input  wire logic [WORD_W-1:0] data_word,    // Measurement word, taken at strobe
	input  wire logic [WORD_W-1:0] id_word,      // Identity word, taken at strobe
	output logic                   rf_data_r,    // Encoded stream to modulator
	output logic                   tx_on_r,      // Modulator enable
	output logic                   word_strobe_r, // Word loaded pulse
	output logic                   id_sel_r,     // Last word loaded was the identity word
	output logic                   moving_r      // Moving mode indicator
);

	////////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	// A whole burst must fit inside one period, or requests would pile up
	if (WORD_W < 2 || HALF_CYC < 2 || HOLD_PERIODS < 1 ||
		PERIOD_TICKS_P <= CHIPS_PER_BIT * BURST_WORDS * WORD_W) begin : g_bad_param
		$error("tstx_sched: parameter out of range");
	end

	localparam int HC_W = $clog2(HALF_CYC);        // Half-bit counter width
	localparam int PC_W = $clog2(PERIOD_TICKS_P);  // Period counter width
	localparam int HD_W = $clog2(HOLD_PERIODS + 1); // Hold counter width
	localparam int BI_W = $clog2(WORD_W);          // Bit index width
	localparam int WL_W = $clog2(BURST_WORDS);     // Words-left width
	localparam logic [HC_W-1:0] HC_LAST = HC_W'(HALF_CYC - 1);
	localparam logic [PC_W-1:0] PC_LAST = PC_W'(PERIOD_TICKS_P - 1);
	localparam logic [HD_W-1:0] HD_LAST = HD_W'(HOLD_PERIODS - 1);
	localparam logic [BI_W-1:0] BI_LAST = BI_W'(WORD_W - 1);
	localparam logic [WL_W-1:0] WL_FULL = WL_W'(BURST_WORDS - 1);

	////////////////////////////////////////////////////////////////////////////
	// State
	logic [HC_W-1:0]   half_cnt_r,  half_cnt_nxt;  // Free-running half-bit divider
	logic [PC_W-1:0]   per_cnt_r,   per_cnt_nxt;   // Burst period counter
	logic [HD_W-1:0]   hold_cnt_r,  hold_cnt_nxt;  // Periods elapsed since motion stopped
	tstx_mode_e        mode_r,      mode_nxt;      // Parked or moving
	logic              burst_pend_r, burst_pend_nxt; // Burst waiting for transmitter
	logic              lf_prev_r,   lf_prev_nxt;   // Last wake-up level
	logic              id_pend_r,   id_pend_nxt;   // Identity word waiting
	tstx_tx_e          tx_r,        tx_nxt;        // Transmitter state
	logic [WORD_W-1:0] sh_r,        sh_nxt;        // Shift register, MSB first
	logic [BI_W-1:0]   bit_idx_r,   bit_idx_nxt;   // Bit within the word
	logic              phase_r,     phase_nxt;     // Second half of bit when set
	logic [WL_W-1:0]   wleft_r,     wleft_nxt;     // Words still to send in burst
	tstx_txo_s         txo_nxt;                    // Next output bundle
	logic              half_tick;                  // Last clock of a half bit
	logic              per_tick;                   // Last clock of a burst period
	logic              moving_nxt;                 // Next mode indicator

	assign half_tick = (half_cnt_r == HC_LAST);
	assign per_tick  = half_tick && (per_cnt_r == PC_LAST);

	////////////////////////////////////////////////////////////////////////////
	// Mode and burst timing, next values
	always_comb begin
		half_cnt_nxt   = half_tick ? '0 : half_cnt_r + 1'b1;
		per_cnt_nxt    = per_cnt_r;
		hold_cnt_nxt   = hold_cnt_r;
		mode_nxt       = mode_r;
		burst_pend_nxt = burst_pend_r;
		lf_prev_nxt    = lf_field;
		id_pend_nxt    = id_pend_r;
		case (mode_r)
			TSTX_PARKED: begin
				// Period and hold counters rest while parked; only motion or a wake-up edge queues anything
				per_cnt_nxt    = '0;
				hold_cnt_nxt   = '0;
				burst_pend_nxt = 1'b0; // R03
				if (motion_closed) begin
					mode_nxt       = TSTX_MOVING; // R04
					burst_pend_nxt = 1'b1;        // R04
				end
			end
			TSTX_MOVING: begin
				if (half_tick)
					per_cnt_nxt = per_tick ? '0 : per_cnt_r + 1'b1;
				if (motion_closed)
					hold_cnt_nxt = '0; // R05
				if (per_tick) begin
					if (!motion_closed && hold_cnt_r == HD_LAST) begin
						// Hold ran out at a period edge, so no burst is cut short
						mode_nxt = TSTX_PARKED; // R06
					end else begin
						burst_pend_nxt = 1'b1; // R04 R05
						if (!motion_closed)
							hold_cnt_nxt = hold_cnt_r + 1'b1; // R05
					end
				end
			end
			default: mode_nxt = TSTX_PARKED;
		endcase
		// Only a real burst start consumes the request; a period tick that
		// finds the transmitter idle must leave its fresh request standing
		if (tx_r == TSTX_IDLE && half_tick && !id_pend_r &&
			burst_pend_r && mode_r == TSTX_MOVING)
			burst_pend_nxt = 1'b0; // R04
		if (tx_r == TSTX_IDLE && half_tick)
			id_pend_nxt = 1'b0;
		// A new field edge wins over the clear in the same cycle
		if (lf_field && !lf_prev_r)
			id_pend_nxt = 1'b1; // R07
		moving_nxt = (mode_nxt == TSTX_MOVING);
	end

	// Mode and burst timing registers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			half_cnt_r   <= '0;
			per_cnt_r    <= '0;
			hold_cnt_r   <= '0;
			mode_r       <= TSTX_PARKED;
			burst_pend_r <= 1'b0;
			lf_prev_r    <= 1'b0;
			id_pend_r    <= 1'b0;
			moving_r     <= 1'b0;
		end else begin
			half_cnt_r   <= half_cnt_nxt;
			per_cnt_r    <= per_cnt_nxt;
			hold_cnt_r   <= hold_cnt_nxt;
			mode_r       <= mode_nxt;
			burst_pend_r <= burst_pend_nxt;
			lf_prev_r    <= lf_prev_nxt;
			id_pend_r    <= id_pend_nxt;
			moving_r     <= moving_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Manchester transmitter, next values
	always_comb begin
		tx_nxt      = tx_r;
		sh_nxt      = sh_r;
		bit_idx_nxt = bit_idx_r;
		phase_nxt   = phase_r;
		wleft_nxt   = wleft_r;
		txo_nxt     = '0;
		txo_nxt.id_sel = id_sel_r;
		// Everything steps on half-bit ticks only, which caps the rate
		if (half_tick) begin // R02
			case (tx_r)
				TSTX_IDLE: begin
					bit_idx_nxt = '0;
					phase_nxt   = 1'b0;
					if (id_pend_r) begin
						// Identity goes out even when parked, a single word
						tx_nxt              = TSTX_SEND; // R07
						sh_nxt              = id_word;
						wleft_nxt           = '0;
						txo_nxt.word_strobe = 1'b1;
						txo_nxt.id_sel      = 1'b1;
					end else if (burst_pend_r && mode_r == TSTX_MOVING) begin
						tx_nxt              = TSTX_SEND; // R04
						sh_nxt              = data_word;
						wleft_nxt           = WL_FULL;
						txo_nxt.word_strobe = 1'b1;
						txo_nxt.id_sel      = 1'b0;
					end
				end
				TSTX_SEND: begin
					phase_nxt = ~phase_r; // R01
					if (phase_r) begin
						if (bit_idx_r == BI_LAST) begin
							bit_idx_nxt = '0;
							if (wleft_r != '0) begin
								// Next word of the burst follows with no gap
								sh_nxt              = data_word;
								wleft_nxt           = wleft_r - 1'b1;
								txo_nxt.word_strobe = 1'b1;
							end else begin
								tx_nxt = TSTX_IDLE;
							end
						end else begin
							sh_nxt      = {sh_r[WORD_W-2:0], 1'b0};
							bit_idx_nxt = bit_idx_r + 1'b1;
						end
					end
				end
				default: tx_nxt = TSTX_IDLE;
			endcase
		end
		txo_nxt.tx_on = (tx_nxt == TSTX_SEND);
		// One: high then low; zero: low then high
		txo_nxt.rf_data = txo_nxt.tx_on && (sh_nxt[WORD_W-1] ^ phase_nxt); // R08
	end

	// Transmitter registers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_r          <= TSTX_IDLE;
			sh_r          <= '0;
			bit_idx_r     <= '0;
			phase_r       <= 1'b0;
			wleft_r       <= '0;
			rf_data_r     <= 1'b0;
			tx_on_r       <= 1'b0;
			word_strobe_r <= 1'b0;
			id_sel_r      <= 1'b0;
		end else begin
			tx_r          <= tx_nxt;
			sh_r          <= sh_nxt;
			bit_idx_r     <= bit_idx_nxt;
			phase_r       <= phase_nxt;
			wleft_r       <= wleft_nxt;
			rf_data_r     <= txo_nxt.rf_data;
			tx_on_r       <= txo_nxt.tx_on;
			word_strobe_r <= txo_nxt.word_strobe;
			id_sel_r      <= txo_nxt.id_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_lf_rise;
		lf_field && !lf_prev_r;
	endsequence
	sequence s_hold_done;
		moving_r && per_tick && !motion_closed && hold_cnt_r == HD_LAST;
	endsequence

	property p_parked_quiet;
		tx_on_r && !id_sel_r |-> moving_r;
	endproperty
	a_parked_quiet: assert property (p_parked_quiet) else $error("burst while parked"); // R03

	property p_enter_moving;
		motion_closed && mode_r == TSTX_PARKED |=> moving_r ##0 burst_pend_r;
	endproperty
	a_enter_moving: assert property (p_enter_moving) else $error("no moving entry"); // R04

	property p_burst_len;
		$rose(tx_on_r) && !id_sel_r |-> wleft_r == WL_FULL;
	endproperty
	a_burst_len: assert property (p_burst_len) else $error("wrong burst length"); // R04

	property p_hold_stays;
		moving_r && !motion_closed && !(per_tick && hold_cnt_r == HD_LAST) |=> moving_r;
	endproperty
	a_hold_stays: assert property (p_hold_stays) else $error("left moving early"); // R05

	property p_hold_ends;
		s_hold_done |=> !moving_r;
	endproperty
	a_hold_ends: assert property (p_hold_ends) else $error("stayed moving"); // R06

	// Every period edge that does not end the hold, with no burst already waiting, queues a new burst
	property p_period_req;
		moving_r && per_tick && !burst_pend_r && (motion_closed || hold_cnt_r != HD_LAST)
			|=> burst_pend_r;
	endproperty
	a_period_req: assert property (p_period_req) else $error("period burst lost"); // R04

	property p_lf_id;
		s_lf_rise |=> id_pend_r;
	endproperty
	a_lf_id: assert property (p_lf_id) else $error("wake-up lost"); // R07

	property p_mid_bit;
		tx_r == TSTX_SEND && !phase_r && half_tick |=> rf_data_r != $past(rf_data_r);
	endproperty
	a_mid_bit: assert property (p_mid_bit) else $error("no mid-bit edge"); // R01

	property p_rate;
		$changed(rf_data_r) |-> $past(half_tick);
	endproperty
	a_rate: assert property (p_rate) else $error("edge off tick"); // R02

	property p_polarity;
		tx_on_r |-> rf_data_r == (sh_r[WORD_W-1] ^ phase_r);
	endproperty
	a_polarity: assert property (p_polarity) else $error("wrong polarity"); // R08

endmodule

//--- tstx_pkg.sv
// Shared constants and types for the tyre sensor transmit scheduler
package tstx_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and link timing
	localparam int unsigned CLK_HZ       = 125_000_000; // Core clock rate
	localparam int unsigned BIT_RATE_BPS = 4096;        // Highest allowed data rate
	localparam int unsigned CHIPS_PER_BIT = 2;          // Manchester halves per bit
	// Least half-bit length, rounded up so the rate never exceeds the limit
	localparam int unsigned HALF_BIT_CYC =
		(CLK_HZ + CHIPS_PER_BIT * BIT_RATE_BPS - 1) / (CHIPS_PER_BIT * BIT_RATE_BPS);
	localparam int unsigned BURST_PERIOD_S = 60;        // One burst each minute
	// Burst period in half-bit ticks
	localparam int unsigned PERIOD_TICKS = BURST_PERIOD_S * CHIPS_PER_BIT * BIT_RATE_BPS;

	////////////////////////////////////////////////////////////////////////////
	// Framing
	localparam int unsigned BURST_WORDS  = 8;  // Words in one moving-mode burst
	localparam int unsigned DEF_WORD_W   = 64; // Word length, layout not fixed here
	localparam int unsigned DEF_HOLD_MIN = 15; // Hold interval in burst periods

	////////////////////////////////////////////////////////////////////////////
	// States
	typedef enum logic {TSTX_PARKED, TSTX_MOVING} tstx_mode_e;
	typedef enum logic {TSTX_IDLE, TSTX_SEND} tstx_tx_e;

	// Transmitter outputs travelling together
	typedef struct packed {
		logic rf_data;     // Manchester chip stream
		logic tx_on;       // Modulator enable
		logic word_strobe; // One-cycle pulse when a word is loaded
		logic id_sel;      // Current word is the identity code
	} tstx_txo_s;

endpackage

//--- tstx_rx.sv
// Behavioural receiver that decodes the scheduler's Manchester stream
`timescale 1ns/1ns
module tstx_rx #(
	parameter int W = 16, // Bits per word
	parameter int H = 4   // Clocks per half bit
) (
	input  wire logic         core_clk, // Core clock
	input  wire logic         rst_b,    // Bench reset, active low
	input  wire logic         rf_data,  // Chip stream
	input  wire logic         tx_on,    // Modulator enable
	input  wire logic         strobe,   // Word start pulse
	input  wire logic         id_sel,   // Identity word flag
	output logic              got,      // One-cycle word pulse
	output logic [W-1:0]      word,     // Decoded word
	output logic              was_id,   // Decoded word was the identity
	output logic              bad       // Coding fault pulse
);
	int   p = -1; // Clocks into the word, -1 when idle
	logic c0;     // First-half chip of the current bit
	logic lr;     // Chip seen at the previous edge

	////////////////////////////////////////////////////////////////////////////
	// Sample each half at its middle; a chip may only change on a half boundary,
	// which is what keeps the line rate at or under the limit
	always @(posedge core_clk) begin
		got <= 1'h0;
		bad <= 1'h0;
		if (strobe === 1'h1) begin
			p = 0;
			was_id <= id_sel;
		end
		if (p < 0) begin
			// Silent line between words
			// Outputs are unknown until the first reset edge, so only judge after it
			if (rst_b === 1'h1 && (rf_data !== 1'h0 || tx_on !== 1'h0)) bad <= 1'h1;
		end else begin
			if (tx_on !== 1'h1 || (p % H != 0 && rf_data !== lr)) bad <= 1'h1;
			if (p % H == H / 2 && (p / H) % 2 == 0) c0 = rf_data;
			if (p % H == H / 2 && (p / H) % 2 == 1) begin
				// Second half must be the inverse: one is high then low
				if (rf_data !== ~c0) bad <= 1'h1;
				word[W-1-p/(2*H)] <= c0;
			end
			p = p + 1;
			if (p == 2 * W * H) begin
				got <= 1'h1;
				p = -1;
			end
		end
		lr = rf_data;
	end
endmodule

//--- tstx_sched_tb.sv
// Self-checking bench for the tyre sensor transmit scheduler
`timescale 1ns/1ns
module tstx_sched_tb;
	import tstx_pkg::*;
	localparam int W = 16;      // Short word keeps bursts brief
	localparam int H = 4;       // Clocks per half bit
	localparam int PT = 400;    // Half bits per burst period
	localparam int PER = PT * H; // Clocks per burst period
	logic         core_clk = 1'h0;
	logic         rst_b = 1'h0;
	logic         motion_closed = 1'h0;
	logic         lf_field = 1'h0;
	logic [W-1:0] data_word = '0;
	logic [W-1:0] id_word = '0;
	wire tstx_txo_s txo;    // Transmitter outputs, one port per member
	logic         moving_r;
	logic         got, was_id, bad;
	logic [W-1:0] word;
	logic [W:0]   exp_q[$]; // Expected {identity flag, word}
	int           fail_count = 0;
	int           n_checks = 0;
	int           cyc = 0;

	tstx_sched #(.WORD_W(W), .HALF_CYC(H), .PERIOD_TICKS_P(PT), .HOLD_PERIODS(2)) dut (
		.core_clk(core_clk), .rst_b(rst_b), .motion_closed(motion_closed),
		.lf_field(lf_field), .data_word(data_word), .id_word(id_word),
		.rf_data_r(txo.rf_data), .tx_on_r(txo.tx_on), .word_strobe_r(txo.word_strobe),
		.id_sel_r(txo.id_sel), .moving_r(moving_r));
	tstx_rx #(.W(W), .H(H)) rx (
		.core_clk(core_clk), .rst_b(rst_b), .rf_data(txo.rf_data), .tx_on(txo.tx_on),
		.strobe(txo.word_strobe), .id_sel(txo.id_sel), .got(got), .word(word),
		.was_id(was_id), .bad(bad));

	initial forever #4 core_clk = ~core_clk;
	always @(posedge core_clk) cyc <= cyc + 1;

	////////////////////////////////////////////////////////////////////////////
	// Compares and helpers
	task automatic cmp_val(input logic [W:0] g, input logic [W:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_flag(input logic g, input logic e);
		cmp_val({{W{1'h0}}, g}, {{W{1'h0}}, e});
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Note eight data words of one burst
	task automatic burst;
		repeat (8) exp_q.push_back({1'h0, data_word});
	endtask
	// Bounded wait for the modulator to switch on; returns the cycle
	task automatic wait_start(output int t);
		int k = 0;
		while (txo.tx_on !== 1'h1 && k < 3 * PER) begin
			tick(1);
			k++;
		end
		t = cyc;
		cmp_flag(txo.tx_on, 1'h1);
	endtask
	// Bounded wait until every noted word arrived and the line is idle
	task automatic wait_idle;
		int k = 0;
		while ((exp_q.size() != 0 || txo.tx_on !== 1'h0) && k < 3 * PER) begin
			tick(1);
			k++;
		end
		cmp_flag(txo.tx_on, 1'h0);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Watcher: every decoded word takes the oldest note; none may come unasked
	always @(posedge core_clk) begin
		if (bad === 1'h1) cmp_flag(bad, 1'h0);
		if (got === 1'h1) begin
			if (exp_q.size() == 0) cmp_flag(got, 1'h0);
			else cmp_val({was_id, word}, exp_q.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int t0, t1;
		t0 = $urandom(5229);
		data_word = W'($urandom);
		id_word = W'($urandom);
		tick(4);
		rst_b = 1'h1;
		tick(2 * PER);
		cmp_flag(moving_r, 1'h0);
		$display("test parked done");
		// Held wake-up field gives a single identity word
		exp_q.push_back({1'h1, id_word});
		lf_field = 1'h1;
		tick(3);
		lf_field = 1'h0;
		wait_start(t0);
		cmp_flag(txo.id_sel, 1'h1);
		wait_idle;
		$display("test wake-up done");
		// Two bursts one period apart
		motion_closed = 1'h1;
		burst;
		wait_start(t0);
		cmp_flag(moving_r, 1'h1);
		wait_idle;
		data_word = W'($urandom);
		burst;
		wait_start(t1);
		cmp_val((W+1)'(t1 - t0), (W+1)'(PER));
		$display("test moving done");
		// Opened just after a burst start: one more burst, then parked
		motion_closed = 1'h0;
		wait_idle;
		burst;
		wait_start(t0);
		cmp_val((W+1)'(t0 - t1), (W+1)'(PER));
		wait_idle;
		tick(PER + 4 * H);
		cmp_flag(moving_r, 1'h0);
		tick(2 * PER);
		cmp_flag(txo.tx_on, 1'h0);
		$display("test hold done");
		close_out;
	end

	// Watchdog against a hang
	initial begin
		tick(14 * PER);
		fail_count++;
		close_out;
	end
endmodule
